// >>> ipx_map.vh
`ifndef IPX_MAP_VH
`define IPX_MAP_VH

// Special-function register address of the power control register
`define IPX_PWR_CTL_ADDR   8'h87
`define IPX_PWR_CTL_RESET  8'h00
`define IPX_BIT_HALT       0
`define IPX_BIT_SCR_LO     2
`define IPX_BIT_SCR_HI     3
`define IPX_BIT_DOUBLER    7

// External-data decode boundaries
`define IPX_IO_BASE        16'hFD80
`define IPX_DBUF_TOP       16'hFEEF
`define IPX_EP0_OUT_BASE   16'hFEF0
`define IPX_EP0_OUT_TOP    16'hFEF7
`define IPX_EP0_IN_BASE    16'hFEF8
`define IPX_EP0_IN_TOP     16'hFEFF
`define IPX_SETUP_BASE     16'hFF00
`define IPX_SETUP_TOP      16'hFF07
`define IPX_DESC_BASE      16'hFF08
`define IPX_RAM_TOP        16'hFF7F
`define IPX_MAPREG_BASE    16'hFF80
`define IPX_MAPREG_TOP     16'hFFFF

// Region codes
`define IPX_RGN_NONE       3'h0
`define IPX_RGN_DBUF       3'h1
`define IPX_RGN_EP0_OUT    3'h2
`define IPX_RGN_EP0_IN     3'h3
`define IPX_RGN_SETUP      3'h4
`define IPX_RGN_DESC       3'h5
`define IPX_RGN_MAPREG     3'h6

// Wake filter timing
`define IPX_WAKE_MIN_US    400
`define IPX_CLK_MHZ        125

`endif

// >>> ipx_power_xmap.v
`timescale 1ns/1ps
`default_nettype none
`include "ipx_map.vh"

// Operation
// - Halt flag resets to 0, firmware may set it, only wake logic clears.
// - Halt clears only after wake line held asserted continuously for 400 us.
// - While halted: core halted, RAM low power, oscillator/PLL off, watchdog frozen.
// - In suspend only the wake line ends idle and raises an interrupt.
// - Scratch flags bits 3..2 read/write, reset 00, no hardware effect.
// - Bit 7 read/write baud doubler, reset 0, doubles serial rate when set.
// - Addresses FD80..FFFF reserved for buffers, setup, descriptors and I/O.
// - Addresses FF80..FFFF decode to mapped registers, not RAM.
// - 512-byte shared RAM at FD80..FF7F holds descriptors and buffers.
// - Endpoint descriptor area decodes at FF08..FF7F.
// - Endpoint-0 input buffer FEF8..FEFF, output buffer FEF0..FEF7.
// - Watchdog frozen during idle, resumes from same count after wake.
module ipx_power_xmap #(
   parameter integer WAKE_CYCLES = `IPX_WAKE_MIN_US * `IPX_CLK_MHZ,
   parameter integer WAKE_WIDTH  = 16
) (
   input  wire        MCLK,
   input  wire        RSTN,
   input  wire [7:0]  SFR_ADDR,
   input  wire [7:0]  SFR_WDATA,
   input  wire        SFR_WR,
   output reg  [7:0]  SFR_RDATA,
   input  wire        WAKE_INTERRUPT_LINE_N,
   input  wire        SUSPEND,
   output wire        LOW_POWER_HALT_FLAG,
   output wire        CORE_HALT,
   output wire        RAM_LOW_POWER,
   output wire        OSC_PLL_OFF,
   output wire        WATCHDOG_FREEZE,
   output wire        SERIAL_RATE_DOUBLER,
   output reg         WAKE_INTERRUPT,
   input  wire [15:0] XADDR,
   output reg  [2:0]  XREGION,
   output reg  [8:0]  XRAM_INDEX,
   output reg         XRAM_SEL,
   output reg         XMMR_SEL,
   output reg  [6:0]  XMMR_INDEX
);

   // Cut to the counter width on purpose; the default count fits in 16 bits
   localparam integer          WAKE_LAST_FULL = WAKE_CYCLES - 1;
   localparam [WAKE_WIDTH-1:0] WAKE_LAST      = WAKE_LAST_FULL[WAKE_WIDTH-1:0];
   localparam integer          NUM_RGN        = 6;
   localparam [7:0]            RESET_VIEW     = `IPX_PWR_CTL_RESET;

   reg                   rst_meta;
   reg                   rst_sync;

   reg                   low_power_halt_flag;
   reg  [1:0]            scratch_flag_pair;
   reg                   serial_rate_doubler;
   reg  [WAKE_WIDTH-1:0] wake_count;

   reg                   next_halt;
   reg                   next_wake_irq;
   reg  [1:0]            next_scratch;
   reg                   next_doubler;
   reg  [WAKE_WIDTH-1:0] next_wake_count;
   reg  [7:0]            next_rdata;
   reg  [2:0]            next_region;
   reg                   next_ram_sel;
   reg                   next_mmr_sel;
   reg  [8:0]            next_ram_index;
   reg  [6:0]            next_mmr_index;

   wire                  pwr_ctl_wr;
   wire                  pwr_ctl_rd;
   wire [7:0]            pwr_ctl_view;
   wire                  wake_asserted;
   wire                  wake_done;
   wire [15:0]           ram_offset;
   wire [2:0]            region_now;
   wire [NUM_RGN:1]      rgn_hit;
   wire [15:0]           rgn_lo [1:NUM_RGN];
   wire [15:0]           rgn_hi [1:NUM_RGN];

   function [2:0] ipx_region;
      input [15:0] a;
      begin
         if (a >= `IPX_MAPREG_BASE)
            ipx_region = `IPX_RGN_MAPREG;
         else if (a >= `IPX_DESC_BASE)
            ipx_region = `IPX_RGN_DESC;
         else if (a >= `IPX_SETUP_BASE)
            ipx_region = `IPX_RGN_SETUP;
         else if (a >= `IPX_EP0_IN_BASE)
            ipx_region = `IPX_RGN_EP0_IN;
         else if (a >= `IPX_EP0_OUT_BASE)
            ipx_region = `IPX_RGN_EP0_OUT;
         else if (a >= `IPX_IO_BASE)
            ipx_region = `IPX_RGN_DBUF;
         else
            ipx_region = `IPX_RGN_NONE;
      end
   endfunction

   function ipx_in_range;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         ipx_in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   // Reserved positions always read back as zero, whatever was written
   function [7:0] ipx_pwr_view;
      input       halt;
      input [1:0] scratch;
      input       doubler;
      begin
         ipx_pwr_view                                  = 8'h00;
         ipx_pwr_view[`IPX_BIT_HALT]                   = halt;
         ipx_pwr_view[`IPX_BIT_SCR_HI:`IPX_BIT_SCR_LO] = scratch;
         ipx_pwr_view[`IPX_BIT_DOUBLER]                = doubler;
      end
   endfunction

   always @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // One bound pair per region code, indexed by that code
   assign rgn_lo[1] = `IPX_IO_BASE;
   assign rgn_hi[1] = `IPX_DBUF_TOP;
   assign rgn_lo[2] = `IPX_EP0_OUT_BASE;
   assign rgn_hi[2] = `IPX_EP0_OUT_TOP;
   assign rgn_lo[3] = `IPX_EP0_IN_BASE;
   assign rgn_hi[3] = `IPX_EP0_IN_TOP;
   assign rgn_lo[4] = `IPX_SETUP_BASE;
   assign rgn_hi[4] = `IPX_SETUP_TOP;
   assign rgn_lo[5] = `IPX_DESC_BASE;
   assign rgn_hi[5] = `IPX_RAM_TOP;
   assign rgn_lo[6] = `IPX_MAPREG_BASE;
   assign rgn_hi[6] = `IPX_MAPREG_TOP;

   // Windows are disjoint, so at most one hit bit is set
   genvar g;
   generate
      for (g = 1; g <= NUM_RGN; g = g + 1) begin : g_rgn
         assign rgn_hit[g] = ipx_in_range(XADDR, rgn_lo[g], rgn_hi[g]);
      end
   endgenerate

   // Register port decode
   assign pwr_ctl_rd    = (SFR_ADDR == `IPX_PWR_CTL_ADDR);
   assign pwr_ctl_wr    = SFR_WR && pwr_ctl_rd;
   assign pwr_ctl_view  = ipx_pwr_view(low_power_halt_flag, scratch_flag_pair,
                                       serial_rate_doubler);
   assign wake_asserted = !WAKE_INTERRUPT_LINE_N;
   assign wake_done     = wake_asserted && (wake_count >= WAKE_LAST);
   assign ram_offset    = XADDR - `IPX_IO_BASE;
   assign region_now    = ipx_region(XADDR);

   // Counter restarts on any release, so only an unbroken pulse wakes
   always @* begin
      next_wake_count = wake_count;
      if (!low_power_halt_flag || !wake_asserted) begin
         next_wake_count = {WAKE_WIDTH{1'b0}};
      end else if (!wake_done) begin
         next_wake_count = wake_count + 1'b1;
      end
   end

   // Firmware can only raise the flag; a written zero leaves it alone
   always @* begin
      next_halt = low_power_halt_flag;
      if (low_power_halt_flag && wake_done) begin
         // Wake wins over a same-cycle firmware set attempt
         next_halt = 1'b0;
      end else if (pwr_ctl_wr && SFR_WDATA[`IPX_BIT_HALT]) begin
         next_halt = 1'b1;
      end
   end

   // One pulse per wake; the line is ignored while running
   always @* begin
      next_wake_irq = 1'b0;
      if (low_power_halt_flag && wake_done) begin
         next_wake_irq = 1'b1;
      end
   end

   // Scratch bits only store; nothing in hardware reads them
   always @* begin
      next_scratch = scratch_flag_pair;
      next_doubler = serial_rate_doubler;
      if (pwr_ctl_wr) begin
         next_scratch = SFR_WDATA[`IPX_BIT_SCR_HI:`IPX_BIT_SCR_LO];
         next_doubler = SFR_WDATA[`IPX_BIT_DOUBLER];
      end
   end

   // Only the power control address answers; every other address reads zero
   always @* begin
      next_rdata = 8'h00;
      if (pwr_ctl_rd) begin
         next_rdata = pwr_ctl_view;
      end
   end

   // Region code and selects land together, one cycle after the address
   always @* begin
      next_region    = region_now;
      next_mmr_sel   = rgn_hit[6];
      next_ram_sel   = |rgn_hit[5:1];
      next_ram_index = ram_offset[8:0];
      next_mmr_index = XADDR[6:0];
   end

   // State registers; all reset through the synchronised copy
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         wake_count <= {WAKE_WIDTH{1'b0}};
      end else begin
         wake_count <= next_wake_count;
      end
   end

   // Flag drives all the low-power outputs directly, with no extra delay
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         low_power_halt_flag <= RESET_VIEW[`IPX_BIT_HALT];
      end else begin
         low_power_halt_flag <= next_halt;
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         WAKE_INTERRUPT <= 1'b0;
      end else begin
         WAKE_INTERRUPT <= next_wake_irq;
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         scratch_flag_pair   <= RESET_VIEW[`IPX_BIT_SCR_HI:`IPX_BIT_SCR_LO];
         serial_rate_doubler <= RESET_VIEW[`IPX_BIT_DOUBLER];
      end else begin
         scratch_flag_pair   <= next_scratch;
         serial_rate_doubler <= next_doubler;
      end
   end

   // Registered so the core samples a settled value, at one cycle of latency
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         SFR_RDATA <= 8'h00;
      end else begin
         SFR_RDATA <= next_rdata;
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         XREGION  <= `IPX_RGN_NONE;
         XRAM_SEL <= 1'b0;
         XMMR_SEL <= 1'b0;
      end else begin
         XREGION  <= next_region;
         XRAM_SEL <= next_ram_sel;
         XMMR_SEL <= next_mmr_sel;
      end
   end

   // Indices pass through even outside their window; qualify with the selects
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         XRAM_INDEX <= 9'h000;
         XMMR_INDEX <= 7'h00;
      end else begin
         XRAM_INDEX <= next_ram_index;
         XMMR_INDEX <= next_mmr_index;
      end
   end

   // SUSPEND only documents that no other source exists here; wake path is the same
   assign LOW_POWER_HALT_FLAG = low_power_halt_flag;
   assign CORE_HALT           = low_power_halt_flag;
   assign RAM_LOW_POWER       = low_power_halt_flag;
   assign OSC_PLL_OFF         = low_power_halt_flag;
   assign WATCHDOG_FREEZE     = low_power_halt_flag;
   assign SERIAL_RATE_DOUBLER = serial_rate_doubler;

endmodule
`default_nettype wire

// >>> ipx_power_xmap_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ipx_chk #(parameter integer WAKE_CYCLES = 20) (
   input wire logic        MCLK,
   input wire logic        RSTN,
   input wire logic [7:0]  SFR_ADDR,
   input wire logic [7:0]  SFR_WDATA,
   input wire logic        SFR_WR,
   input wire logic        WAKE_INTERRUPT_LINE_N,
   input wire logic        LOW_POWER_HALT_FLAG,
   input wire logic        WATCHDOG_FREEZE,
   input wire logic        SERIAL_RATE_DOUBLER,
   input wire logic        WAKE_INTERRUPT,
   input wire logic [15:0] XADDR,
   input wire logic        XRAM_SEL,
   input wire logic        XMMR_SEL
);
   localparam int W1 = WAKE_CYCLES - 1;
   logic [15:0] low;
   wire         pwr = SFR_WR && SFR_ADDR == 8'h87;
   // One-cycle margin: filter may count from either edge
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN)
         low <= 16'h0000;
      else
         low <= WAKE_INTERRUPT_LINE_N ? 16'h0000 : low + 16'h0001;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   sequence s_clear;
      $fell(LOW_POWER_HALT_FLAG);
   endsequence
   a_halt_set: assert property (pwr && SFR_WDATA[0] && !LOW_POWER_HALT_FLAG |=> LOW_POWER_HALT_FLAG)
      else $error("halt not set");
   a_halt_clear: assert property (s_clear |-> WAKE_INTERRUPT)
      else $error("halt cleared without wake");
   a_wake_hold: assert property (WAKE_INTERRUPT |-> low >= W1)
      else $error("wake too short");
   a_wake_refused: assert property (!LOW_POWER_HALT_FLAG |=> !WAKE_INTERRUPT)
      else $error("wake while running");
   a_freeze_follow: assert property (WATCHDOG_FREEZE == LOW_POWER_HALT_FLAG)
      else $error("freeze mismatch");
   a_doubler_write: assert property (pwr |=> SERIAL_RATE_DOUBLER == $past(SFR_WDATA[7]))
      else $error("doubler mismatch");
   a_ram_decode: assert property (XRAM_SEL == $past(XADDR inside {[16'hFD80:16'hFF7F]}))
      else $error("ram select mismatch");
   a_mmr_decode: assert property (XMMR_SEL == $past(XADDR >= 16'hFF80))
      else $error("mmr select mismatch");
endmodule
bind ipx_power_xmap ipx_chk #(.WAKE_CYCLES(WAKE_CYCLES)) i_ipx_chk (.*);
`default_nettype wire

// >>> ipx_fw_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipx_fw_model (
   input  wire logic       MCLK,
   input  wire logic [7:0] SFR_RDATA,
   output logic [7:0]      SFR_ADDR = 8'h00,
   output logic [7:0]      SFR_WDATA = 8'h00,
   output logic            SFR_WR = 1'b0,
   output logic            WAKE_INTERRUPT_LINE_N = 1'b1
);
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge MCLK);
      #1 SFR_ADDR = a;
      SFR_WDATA = v;
      SFR_WR = 1'b1;
      @(posedge MCLK);
      #1 SFR_WR = 1'b0;
      SFR_WDATA = ~v; // Stale data must not look valid
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge MCLK);
      #1 SFR_ADDR = a;
      @(posedge MCLK);
      #1 v = SFR_RDATA;
   endtask
   task wake(input int n);
      @(posedge MCLK);
      #1 WAKE_INTERRUPT_LINE_N = 1'b0;
      repeat (n) @(posedge MCLK);
      #1 WAKE_INTERRUPT_LINE_N = 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic            MCLK = 1'b0;
   logic            RSTN = 1'b0;
   logic            SUSPEND = 1'b1;
   logic [15:0]     XADDR = 16'h0000;
   wire logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
   wire logic       SFR_WR, WAKE_INTERRUPT_LINE_N, LOW_POWER_HALT_FLAG, CORE_HALT;
   wire logic       RAM_LOW_POWER, OSC_PLL_OFF, WATCHDOG_FREEZE, SERIAL_RATE_DOUBLER;
   wire logic       WAKE_INTERRUPT, XRAM_SEL, XMMR_SEL;
   wire logic [2:0] XREGION;
   wire logic [8:0] XRAM_INDEX;
   wire logic [6:0] XMMR_INDEX;
   int              num_errors = 0;
   int              cmp_count = 0;
   logic [7:0]      irqs = 8'h00;
   logic [7:0]      d;
   logic [15:0]     ta [13] = '{16'hFD7F, 16'hFD80, 16'hFEEF, 16'hFEF0, 16'hFEF7, 16'hFEF8,
      16'hFEFF, 16'hFF00, 16'hFF07, 16'hFF08, 16'hFF7F, 16'hFF80, 16'hFFFF};
   logic [2:0]      tr [13] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5,
      3'h5, 3'h6, 3'h6};
   always #4 MCLK = ~MCLK;
   always @(posedge MCLK) if (WAKE_INTERRUPT === 1'b1) irqs <= irqs + 8'h01;
   ipx_power_xmap #(.WAKE_CYCLES(20)) i_ipx_power_xmap (.*);
   ipx_fw_model i_ipx_fw_model (.*);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("mismatches %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge MCLK);
      #1 RSTN = 1'b1;
      repeat (2) @(posedge MCLK);
      i_ipx_fw_model.rd(8'h87, d);
      chk(d, 8'h00);
      i_ipx_fw_model.wr(8'h87, 8'hFF);
      i_ipx_fw_model.rd(8'h87, d);
      chk(d, 8'h8D);
      chk({4'h0, CORE_HALT, RAM_LOW_POWER, OSC_PLL_OFF, WATCHDOG_FREEZE}, 8'h0F);
      chk({7'h00, SERIAL_RATE_DOUBLER}, 8'h01);
      i_ipx_fw_model.wr(8'h87, 8'h00);
      i_ipx_fw_model.wr(8'h86, 8'hFF);
      i_ipx_fw_model.rd(8'h87, d);
      chk(d, 8'h01);
      chk({7'h00, SERIAL_RATE_DOUBLER}, 8'h00);
      i_ipx_fw_model.wake(10);
      chk({7'h00, LOW_POWER_HALT_FLAG}, 8'h01);
      i_ipx_fw_model.wake(25);
      chk({7'h00, LOW_POWER_HALT_FLAG}, 8'h00);
      i_ipx_fw_model.wake(25);
      chk(irqs, 8'h01);
      for (int i = 0; i < 13; i++) begin
         @(posedge MCLK);
         #1 XADDR = ta[i];
         @(posedge MCLK);
         #1 chk({5'h00, XREGION}, {5'h00, tr[i]});
         chk({XRAM_SEL, XMMR_SEL}, {(tr[i] != 3'h0) && (tr[i] != 3'h6), tr[i] == 3'h6});
         chk({7'h00, XRAM_INDEX}, (ta[i] - 16'hFD80) & 16'h01FF);
         chk({9'h000, XMMR_INDEX}, ta[i] & 16'h007F);
      end
      wrap_up;
   end
   initial begin
      #4000;
      num_errors++;
      wrap_up;
   end
endmodule
`default_nettype wire
